/* adc_seq_pkg.sv */
// constants, types and register map of the conversion sequencer
package adc_seq_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_INPUT_SELECT = 8'h00;
  localparam logic [7:0] OFS_CTRL_A = 8'h04;
  localparam logic [7:0] OFS_CTRL_B = 8'h08;
  localparam logic [7:0] OFS_RESULT_LOW = 8'h0C;
  localparam logic [7:0] OFS_RESULT_HIGH = 8'h10;
  localparam logic [7:0] OFS_POWER_RED = 8'h14;
  // conv_control_status_a fields
  localparam int CA_ENABLE = 7;
  localparam int CA_START = 6;
  localparam int CA_AUTO = 5;
  localparam int CA_FLAG = 4;
  localparam int CA_IE = 3;
  localparam int CA_PS_LSB = 0;
  // input_select_reg fields
  localparam int SEL_REF_LSB = 6;
  localparam int SEL_LEFT = 5;
  localparam int SEL_CH_LSB = 0;
  // reset values
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [2:0] PS_RST = 3'h0;
  localparam logic [2:0] SRC_RST = 3'h0;
  localparam logic PWR_RED_RST = 1'b0;
  // trigger source code that selects the done flag (free running)
  localparam logic [2:0] SRC_DONE_FLAG = 3'h0;
  // conversion timing, in converter clock cycles
  localparam int CYC_LEN_NORMAL = 13;
  localparam int CYC_LEN_FIRST = 25;
  // timing in half converter cycles
  localparam logic [5:0] HALF_LEN_NORMAL = 6'(2 * CYC_LEN_NORMAL);
  localparam logic [5:0] HALF_LEN_FIRST = 6'(2 * CYC_LEN_FIRST);
  localparam logic [5:0] HALF_LEN_AUTO = 6'h1B;
  localparam logic [5:0] HALF_SH_NORMAL = 6'h03;
  localparam logic [5:0] HALF_SH_FIRST = 6'h1B;
  localparam logic [5:0] HALF_SH_AUTO = 6'h04;
  // cpu cycles spent synchronising a trigger edge
  localparam int SYNC_CPU_CYCLES = 3;
  // successive approximation
  localparam int RESULT_BITS = 10;
  localparam logic [9:0] SAR_MSB = 10'h200;
  localparam logic [3:0] SAR_TOP_BIT = 4'h9;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_CONV = 2'b10
  } conv_state_e;

  typedef struct packed {
    logic [1:0] reference;
    logic [3:0] channel;
  } mux_sel_s;
endpackage : adc_seq_pkg

/* adc_prescaler.sv */
// divider that makes the converter clock as rise and fall tick pulses
`timescale 1ns/1ps
`default_nettype none
module adc_prescaler (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hold,
  input wire logic [2:0] prescaler_select,
  output logic tick_rise,
  output logic tick_fall
);
  logic [6:0] cnt_r;
  logic level_r;
  logic [6:0] half_limit;

  // half period of divide by 2..128
  function automatic logic [6:0] half_period(input logic [2:0] s);
    if (s <= 3'h1) begin
      return 7'h01;
    end
    return 7'(7'h01 << (s - 3'h1));
  endfunction : half_period

  assign half_limit = half_period(prescaler_select) - 7'h01;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 7'h00;
      level_r <= 1'b0;
      tick_rise <= 1'b0;
      tick_fall <= 1'b0;
    end else if (hold) begin
      cnt_r <= 7'h00;
      level_r <= 1'b0;
      tick_rise <= 1'b0;
      tick_fall <= 1'b0;
    end else if (cnt_r >= half_limit) begin
      cnt_r <= 7'h00;
      level_r <= ~level_r;
      tick_rise <= ~level_r;
      tick_fall <= level_r;
    end else begin
      cnt_r <= cnt_r + 7'h01;
      tick_rise <= 1'b0;
      tick_fall <= 1'b0;
    end
  end
endmodule : adc_prescaler
`default_nettype wire

/* adc_conversion_sequencer.sv */
// conversion sequencer with apb registers, trigger logic and sar control
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] trigger_in,
  input wire logic irq_ack,
  input wire logic comparator_in,
  output adc_seq_pkg::mux_sel_s mux_sel,
  output logic analog_enable,
  output logic sample_hold,
  output logic [9:0] dac_code,
  output logic conv_irq
);
  import adc_seq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic [7:0] sel_reg_r;
  logic en_r, start_r, auto_r, flag_r, ie_r, pwr_red_r;
  logic [2:0] ps_r, src_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;
  logic wr_en, rd_cap;
  logic [31:0] rdata;
  logic mapped;
  logic lock_r;
  logic [9:0] result_r, dac_r;
  conv_state_e state_r;
  logic [5:0] half_r, len_r, sh_r;
  logic first_r, stepping_r;
  logic [3:0] bit_r;
  logic sample_r, irq_r, clr_r;
  mux_sel_s active_r;
  logic conv_on, tick_rise, tick_fall, tick, done, near_end;
  logic start_wr, free_run, trig_level, trig_prev_r, trig_edge;
  logic [SYNC_CPU_CYCLES-1:0] trig_sh_r;
  logic trig_fire;
  logic comp_q1_r, comp_q2_r, comp_q3_r, comp_s_r;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [7:0] fmt_byte(input logic [9:0] res, input logic left, input logic high);
    if (left) begin
      return high ? res[9:2] : {res[1:0], 6'h00};
    end
    return high ? {6'h00, res[9:8]} : res[7:0];
  endfunction : fmt_byte

  function automatic logic [9:0] sar_step(input logic [9:0] d, input logic [3:0] b, input logic keep);
    logic [9:0] n;
    n = d;
    if (!keep) begin
      n[b] = 1'b0;
    end
    if (b != 4'h0) begin
      n[b - 4'h1] = 1'b1;
    end
    return n;
  endfunction : sar_step

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, one wait cycle
  assign wr_en = psel && penable && pready_r && pwrite;
  assign rd_cap = psel && penable && !pready_r && !pwrite;
  assign mapped = (paddr == OFS_INPUT_SELECT) || (paddr == OFS_CTRL_A) || (paddr == OFS_CTRL_B) ||
                  (paddr == OFS_RESULT_LOW) || (paddr == OFS_RESULT_HIGH) || (paddr == OFS_POWER_RED);

  always_comb begin
    rdata = 32'h0000_0000;
    case (paddr)
      OFS_INPUT_SELECT: rdata[7:0] = sel_reg_r;
      OFS_CTRL_A: rdata[7:0] = {en_r, start_r, auto_r, flag_r, ie_r, ps_r};
      OFS_CTRL_B: rdata[2:0] = src_r;
      OFS_RESULT_LOW: rdata[7:0] = fmt_byte(result_r, sel_reg_r[SEL_LEFT], 1'b0);
      OFS_RESULT_HIGH: rdata[7:0] = fmt_byte(result_r, sel_reg_r[SEL_LEFT], 1'b1);
      OFS_POWER_RED: rdata[0] = pwr_red_r;
      default: rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= psel && penable && !pready_r;
      pslverr_r <= psel && penable && !pready_r && !mapped;
      if (rd_cap) begin
        prdata_r <= rdata;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_reg_r <= SEL_RST;
      en_r <= 1'b0;
      auto_r <= 1'b0;
      ie_r <= 1'b0;
      ps_r <= PS_RST;
      src_r <= SRC_RST;
      pwr_red_r <= PWR_RED_RST;
    end else if (wr_en) begin
      case (paddr)
        OFS_INPUT_SELECT: sel_reg_r <= pwdata[7:0] & 8'hEF;
        OFS_CTRL_A: begin
          en_r <= pwdata[CA_ENABLE];
          auto_r <= pwdata[CA_AUTO];
          ie_r <= pwdata[CA_IE];
          ps_r <= pwdata[CA_PS_LSB +: 3];
        end
        OFS_CTRL_B: src_r <= pwdata[2:0];
        OFS_POWER_RED: pwr_red_r <= pwdata[0];
        default: ;
      endcase
    end
  end

  assign conv_on = en_r && !pwr_red_r;
  assign start_wr = wr_en && (paddr == OFS_CTRL_A) && pwdata[CA_START] && pwdata[CA_ENABLE] && !pwr_red_r;
  assign free_run = auto_r && (src_r == SRC_DONE_FLAG);

  ////////////////////////////////////////////////////////////////////////////
  // result lock between low and high byte reads
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_r <= 1'b0;
    end else if (rd_cap && paddr == OFS_RESULT_HIGH) begin
      lock_r <= 1'b0;
    end else if (rd_cap && paddr == OFS_RESULT_LOW) begin
      lock_r <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_r <= 10'h000;
    end else if (done && !lock_r) begin
      result_r <= dac_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // done flag, set wins over clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      flag_r <= done || (flag_r && !(irq_ack || (wr_en && paddr == OFS_CTRL_A && pwdata[CA_FLAG])));
      irq_r <= flag_r && ie_r;
    end
  end

  assign conv_irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // converter clock
  adc_prescaler u_prescaler (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .hold(!conv_on || clr_r),
    .prescaler_select(ps_r),
    .tick_rise(tick_rise),
    .tick_fall(tick_fall)
  );

  assign tick = (tick_rise || tick_fall) && !clr_r;
  assign done = (state_r == ST_CONV) && tick && (half_r == len_r - 6'h01);
  assign near_end = (half_r >= len_r - 6'h02);

  ////////////////////////////////////////////////////////////////////////////
  // trigger edge detect and cpu synchronisation
  assign trig_level = (src_r == SRC_DONE_FLAG) ? 1'b0 : trigger_in[src_r];
  assign trig_edge = trig_level && !trig_prev_r;
  assign trig_fire = trig_sh_r[SYNC_CPU_CYCLES-1];

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_prev_r <= 1'b0;
      trig_sh_r <= '0;
    end else begin
      trig_prev_r <= trig_level;
      trig_sh_r <= {trig_sh_r[SYNC_CPU_CYCLES-2:0], trig_edge && auto_r && conv_on};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // comparator pin synchroniser
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      comp_q1_r <= 1'b0;
      comp_q2_r <= 1'b0;
      comp_q3_r <= 1'b0;
      comp_s_r <= 1'b0;
    end else begin
      comp_q1_r <= comparator_in;
      comp_q2_r <= comp_q1_r;
      comp_q3_r <= comp_q2_r;
      if (comp_q2_r == comp_q3_r) begin
        comp_s_r <= comp_q3_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // conversion state machine
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      half_r <= 6'h00;
      len_r <= HALF_LEN_NORMAL;
      sh_r <= HALF_SH_NORMAL;
      start_r <= 1'b0;
      first_r <= 1'b1;
      clr_r <= 1'b0;
    end else if (!conv_on && !start_wr) begin
      state_r <= ST_IDLE;
      half_r <= 6'h00;
      start_r <= 1'b0;
      first_r <= 1'b1;
      clr_r <= 1'b0;
    end else begin
      clr_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          half_r <= 6'h00;
          len_r <= first_r ? HALF_LEN_FIRST : HALF_LEN_NORMAL;
          sh_r <= first_r ? HALF_SH_FIRST : HALF_SH_NORMAL;
          if (start_wr) begin
            start_r <= 1'b1;
            state_r <= ST_ARMED;
          end else if (trig_fire && !free_run) begin
            start_r <= 1'b1;
            clr_r <= 1'b1;
            len_r <= first_r ? HALF_LEN_FIRST : HALF_LEN_AUTO;
            sh_r <= first_r ? HALF_SH_FIRST : HALF_SH_AUTO;
            state_r <= ST_CONV;
          end
        end
        ST_ARMED: begin
          if (tick_rise) begin
            state_r <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (done) begin
            first_r <= 1'b0;
            half_r <= 6'h00;
            if (free_run) begin
              len_r <= HALF_LEN_NORMAL;
              sh_r <= HALF_SH_NORMAL;
            end else begin
              start_r <= 1'b0;
              state_r <= ST_IDLE;
            end
          end else if (tick) begin
            half_r <= half_r + 6'h01;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample and hold plus successive approximation
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_r <= 1'b0;
      stepping_r <= 1'b0;
      bit_r <= SAR_TOP_BIT;
      dac_r <= 10'h000;
    end else begin
      sample_r <= 1'b0;
      if (state_r != ST_CONV || !conv_on) begin
        stepping_r <= 1'b0;
      end else if (tick && !done && (half_r + 6'h01 == sh_r)) begin
        sample_r <= 1'b1;
        stepping_r <= 1'b1;
        bit_r <= SAR_TOP_BIT;
        dac_r <= SAR_MSB;
      end else if (tick_rise && !clr_r && stepping_r) begin
        dac_r <= sar_step(dac_r, bit_r, comp_s_r);
        bit_r <= bit_r - 4'h1;
        stepping_r <= (bit_r != 4'h0);
      end
    end
  end

  assign sample_hold = sample_r;
  assign dac_code = dac_r;

  ////////////////////////////////////////////////////////////////////////////
  // channel and reference buffer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_r <= '0;
      analog_enable <= 1'b0;
    end else begin
      analog_enable <= conv_on;
      if (conv_on && (state_r != ST_CONV || near_end)) begin
        active_r.reference <= sel_reg_r[SEL_REF_LSB +: 2];
        active_r.channel <= sel_reg_r[SEL_CH_LSB +: 4];
      end
    end
  end

  assign mux_sel = active_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  lock_keeps_result_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    lock_r && done |=> $stable(result_r)) else $error("result changed while locked");
  unlock_high_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rd_cap && paddr == OFS_RESULT_HIGH |=> !lock_r) else $error("lock not released");
  flag_on_discard_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    done && lock_r |=> flag_r) else $error("flag missing on discard");
  single_clears_start_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    done && !free_run |=> !start_r && state_r == ST_IDLE) else $error("start not cleared");
  busy_reads_start_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_r != ST_IDLE |-> start_r) else $error("start bit low while busy");
  armed_on_rise_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_r == ST_ARMED && tick_rise && conv_on |=> state_r == ST_CONV && half_r == 6'h00)
    else $error("armed start missed rise");
  sel_frozen_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    state_r == ST_CONV && !near_end && $past(state_r) == ST_CONV |=> $stable(active_r))
    else $error("selection moved mid conversion");
  prescaler_held_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !conv_on [*2] |-> !tick_rise && !tick_fall) else $error("prescaler ran while off");
  free_run_stays_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    done && free_run && conv_on |=> state_r == ST_CONV && start_r) else $error("free run stopped");
  normal_sample_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    sample_r && len_r == HALF_LEN_NORMAL |-> half_r == HALF_SH_NORMAL) else $error("sample time off");
  left_low_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rd_cap && paddr == OFS_RESULT_LOW && sel_reg_r[SEL_LEFT] |=> prdata_r[5:0] == 6'h00)
    else $error("left aligned low byte wrong");

  done_seen_c: cover property (@(posedge ref_clk) disable iff (!rst_n) done);
  discard_c: cover property (@(posedge ref_clk) disable iff (!rst_n) done && lock_r);
  auto_start_c: cover property (@(posedge ref_clk) disable iff (!rst_n) clr_r);
  free_run_c: cover property (@(posedge ref_clk) disable iff (!rst_n) done && free_run);
endmodule : adc_conversion_sequencer
`default_nettype wire

/* adc_analog_model.sv */
// analog side model: input multiplexer, sample and hold, comparator
`timescale 1ns/1ps
`default_nettype none
module adc_analog_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sample_hold,
  input wire logic analog_enable,
  input wire adc_seq_pkg::mux_sel_s mux_sel,
  input wire logic [9:0] dac_code,
  output logic comparator_in
);
  import adc_seq_pkg::*;
  logic [9:0] held_r;
  logic tgl_r;
  ////////////////////////////////////////////////////////////////
  // each channel carries its own fixed level
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      held_r <= 10'h000;
    end else if (sample_hold) begin
      held_r <= {mux_sel.channel, 6'h15};
    end
  end
  // powered down comparator gives no steady answer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tgl_r <= 1'b0;
    end else begin
      tgl_r <= ~tgl_r;
    end
  end
  assign comparator_in = analog_enable ? (held_r >= dac_code) : tgl_r;
endmodule : adc_analog_model
`default_nettype wire

/* test_adc_conversion_sequencer.sv */
// self-checking bench of the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
`define chk(nm, e, s) begin checked++; if ((s) !== (e)) begin bad_count++; $display("unexpected %s exp %h got %h", nm, e, s); end end
module test_adc_conversion_sequencer;
  import adc_seq_pkg::*;
  typedef struct packed {logic wr; logic [7:0] a; logic [7:0] d; logic [7:0] x; logic e;} row_s;
  logic ref_clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, irq_ack = 1'b0;
  logic [7:0] paddr = 8'h00, trigger_in = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, comparator_in, analog_enable, sample_hold, conv_irq, er, irq_q = 1'b0;
  mux_sel_s mux_sel;
  logic [9:0] dac_code;
  int bad_count = 0, checked = 0, cyc = 0, sh_n = 0, sh_t = 0, done_t = 0, t0 = 0, te = 0, n0 = 0;
  row_s rows [12] = '{
    '{1'b0, OFS_INPUT_SELECT, 8'h00, SEL_RST, 1'b0}, '{1'b0, OFS_CTRL_A, 8'h00, 8'h00, 1'b0},
    '{1'b0, OFS_CTRL_B, 8'h00, {5'h00, SRC_RST}, 1'b0}, '{1'b0, OFS_RESULT_LOW, 8'h00, 8'h00, 1'b0},
    '{1'b0, OFS_RESULT_HIGH, 8'h00, 8'h00, 1'b0}, '{1'b0, OFS_POWER_RED, 8'h00, 8'h00, 1'b0},
    '{1'b1, OFS_INPUT_SELECT, 8'hFF, 8'h00, 1'b0}, '{1'b0, OFS_INPUT_SELECT, 8'h00, 8'hEF, 1'b0},
    '{1'b1, OFS_CTRL_B, 8'hFF, 8'h00, 1'b0}, '{1'b0, OFS_CTRL_B, 8'h00, 8'h07, 1'b0},
    '{1'b1, 8'h20, 8'h55, 8'h00, 1'b1}, '{1'b0, 8'h20, 8'h00, 8'h00, 1'b1}};
  ////////////////////////////////////////////////////////////////
  adc_conversion_sequencer u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trigger_in(trigger_in), .irq_ack(irq_ack), .comparator_in(comparator_in), .mux_sel(mux_sel),
    .analog_enable(analog_enable), .sample_hold(sample_hold), .dac_code(dac_code), .conv_irq(conv_irq));
  adc_analog_model u_analog (.ref_clk(ref_clk), .rst_n(rst_n), .sample_hold(sample_hold),
    .analog_enable(analog_enable), .mux_sel(mux_sel), .dac_code(dac_code), .comparator_in(comparator_in));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  // cycle count, sampling instants and completions
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (sample_hold === 1'b1) begin
      sh_n <= sh_n + 1;
      sh_t <= cyc;
    end
    if (conv_irq === 1'b1 && irq_q !== 1'b1) done_t <= cyc;
    irq_q <= conv_irq;
  end
  ////////////////////////////////////////////////////////////////
  task automatic test_done;
    if (bad_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb
  // control word: enable, flag clear, irq enable, divide by 16
  task automatic go(input logic s, input logic au);
    apb(1'b1, OFS_CTRL_A, {1'b1, s, au, 5'h1C});
    t0 = cyc - 1;
  endtask : go
  task automatic wait_done;
    int o, n;
    o = done_t;
    n = 0;
    while (done_t == o && n < 3000) begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 3000) begin
      bad_count++;
      test_done();
    end
  endtask : wait_done
  task automatic rdb(input logic [7:0] a);
    apb(1'b0, a, 8'h00);
  endtask : rdb
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      `chk("pslverr", rows[i].e, er)
      if (!rows[i].wr) `chk("read", rows[i].x, rd[7:0])
    end
    `chk("mux off", 6'h00, mux_sel)
    apb(1'b1, OFS_CTRL_B, 8'h00);
    apb(1'b1, OFS_INPUT_SELECT, 8'h05);
    go(1'b1, 1'b0);
    wait_done();
    `chk("first len", 1'b1, (done_t - t0) inside {[400:420]})
    `chk("first sh", 1'b1, (done_t - sh_t) inside {[183:189]})
    rdb(OFS_CTRL_A);
    `chk("start clr", 2'b01, {rd[6], rd[4]})
    rdb(OFS_RESULT_LOW);
    `chk("low r", 8'h55, rd[7:0])
    rdb(OFS_RESULT_HIGH);
    `chk("high r", 8'h01, rd[7:0])
    apb(1'b1, OFS_INPUT_SELECT, 8'h25);
    rdb(OFS_RESULT_LOW);
    `chk("low l", 8'h40, rd[7:0])
    rdb(OFS_RESULT_HIGH);
    `chk("high l", 8'h55, rd[7:0])
    apb(1'b1, OFS_INPUT_SELECT, 8'h06);
    go(1'b1, 1'b0);
    repeat (40) @(posedge ref_clk);
    rdb(OFS_CTRL_A);
    `chk("start busy", 1'b1, rd[6])
    apb(1'b1, OFS_INPUT_SELECT, 8'h02);
    `chk("ch held", 4'h6, mux_sel.channel)
    wait_done();
    `chk("norm len", 1'b1, (done_t - t0) inside {[208:228]})
    `chk("norm sh", 1'b1, (done_t - sh_t) inside {[183:189]})
    repeat (3) @(posedge ref_clk);
    `chk("ch next", 4'h2, mux_sel.channel)
    rdb(OFS_RESULT_LOW);
    `chk("low ch6", 8'h95, rd[7:0])
    go(1'b1, 1'b0);
    wait_done();
    rdb(OFS_CTRL_A);
    `chk("flag lost", 1'b1, rd[4])
    rdb(OFS_RESULT_HIGH);
    `chk("high kept", 8'h01, rd[7:0])
    go(1'b1, 1'b0);
    wait_done();
    rdb(OFS_RESULT_LOW);
    `chk("low new", 8'h95, rd[7:0])
    rdb(OFS_RESULT_HIGH);
    `chk("high new", 8'h00, rd[7:0])
    irq_ack <= 1'b1;
    @(posedge ref_clk);
    irq_ack <= 1'b0;
    repeat (2) @(posedge ref_clk);
    `chk("irq ack", 1'b0, conv_irq)
    apb(1'b1, OFS_CTRL_B, 8'h03);
    go(1'b0, 1'b1);
    n0 = sh_n;
    trigger_in[3] <= 1'b1;
    te = cyc;
    repeat (60) @(posedge ref_clk);
    trigger_in[3] <= 1'b0;
    rdb(OFS_CTRL_A);
    `chk("start auto", 1'b1, rd[6])
    repeat (20) @(posedge ref_clk);
    trigger_in[3] <= 1'b1;
    repeat (600) @(posedge ref_clk);
    `chk("trig sh", 1'b1, (sh_t - te) inside {[33:39]})
    `chk("trig once", 1, sh_n - n0)
    trigger_in[3] <= 1'b0;
    apb(1'b1, OFS_CTRL_B, 8'h00);
    n0 = sh_n;
    go(1'b0, 1'b1);
    repeat (300) @(posedge ref_clk);
    `chk("no self start", 0, sh_n - n0)
    go(1'b1, 1'b1);
    repeat (700) @(posedge ref_clk);
    `chk("free runs", 1'b1, (sh_n - n0) inside {[3:4]})
    rdb(OFS_CTRL_A);
    `chk("start free", 1'b1, rd[6])
    apb(1'b1, OFS_CTRL_A, 8'h00);
    apb(1'b1, OFS_POWER_RED, 8'h01);
    n0 = sh_n;
    go(1'b1, 1'b0);
    repeat (400) @(posedge ref_clk);
    `chk("pwr off", 1'b0, analog_enable)
    `chk("pwr idle", 0, sh_n - n0)
    test_done();
  end
endmodule : test_adc_conversion_sequencer
`default_nettype wire
